// [oms_pkg.sv]
package oms_pkg;
    // fixed mapping of the three selection bits to modes
    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE    = 3'h0,
        CRYSTAL_RESONATOR_MODE    = 3'h1,
        HIGH_SPEED_CRYSTAL_MODE   = 3'h2,
        EXTERNAL_CLOCK_IO_MODE    = 3'h3,
        INTERNAL_OSC_IO_MODE      = 3'h4,
        INTERNAL_OSC_CLKOUT_MODE  = 3'h5,
        EXT_RC_IO_MODE            = 3'h6,
        EXT_RC_CLKOUT_MODE        = 3'h7
    } oms_mode_e;

    // clock source choices
    typedef enum logic [1:0] {
        SRC_RESONATOR = 2'h0,
        SRC_EXT_RC    = 2'h1,
        SRC_INTERNAL  = 2'h2,
        SRC_EXT_CLOCK = 2'h3
    } oms_src_e;

    // start-up, run and sleep states
    typedef enum logic [1:0] {
        ST_START = 2'h0,
        ST_RUN   = 2'h1,
        ST_SLEEP = 2'h2
    } oms_state_e;

    localparam int OMS_DIV = 4;              // clock-out is a quarter of the rate
    localparam int OMS_STARTUP_US = 1;       // start-up wait of oscillator modes
    localparam int OMS_CLK_MHZ = 25;
    localparam int OMS_STARTUP_CYC = OMS_STARTUP_US * OMS_CLK_MHZ;
    localparam int OMS_CNT_W = 16;
    localparam logic [1:0] OMS_DIV_LAST = 2'h3;
    localparam logic [1:0] OMS_DIV_HALF = 2'h1;

    // port bit bundle: bit 0 is port bit 6, bit 1 is port bit 7
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } oms_pins_s;

    // whole module state
    typedef struct packed {
        oms_mode_e mode;
        oms_src_e src;
        oms_state_e state;
        logic [OMS_CNT_W-1:0] cnt;
        logic [1:0] div;
        logic clk_run;
        logic osc_drive;
        logic [1:0] gpio_en;
        logic [1:0] port_rd;
        oms_pins_s pins;
        logic [1:0] sync1;
        logic [1:0] sync2;
    } oms_state_s;
endpackage

// [oms_select.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - three select bits choose one of eight modes
// - crystal modes run oscillator across both pins
// - ext rc clkout drives quarter rate out
// - ext rc io frees port bit six
// - internal clkout: quarter rate, bit seven io
// - internal io frees both port bits
// - external clock mode has no start-up wait
// - external clock mode: output pin is bit six
module oms_select
    import oms_pkg::*;
#(
    parameter int STARTUP_CYC = OMS_STARTUP_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration and power control
    input wire logic [2:0] osc_select_bits,
    input wire logic sleep_req,
    input wire logic wake,
    // port write data and pin levels (bit 0 = port bit 6, bit 1 = port bit 7)
    input wire logic [1:0] port_wr_data,
    input wire logic [1:0] port_dir_out,
    input wire logic [1:0] pin_in,
    // status and clock source
    output logic [2:0] mode,
    output logic [1:0] clk_src,
    output logic osc_drive_en,
    output logic clk_run,
    output logic [1:0] gpio_en,
    output logic [1:0] port_rd,
    // pin drive
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe
);
    // elaboration checks: the counter must hold the wait, the divider constants must agree
    if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << OMS_CNT_W)) begin : g_bad_startup
        $error("startup count out of range");
    end
    if (int'(OMS_DIV_LAST) + 1 != OMS_DIV) begin : g_bad_divider
        $error("divider constants disagree");
    end

    oms_state_s r;
    oms_state_s next_r;
    logic [OMS_CNT_W-1:0] start_last;

    assign start_last = OMS_CNT_W'(STARTUP_CYC - 1);

    // next state: mode decode, start-up, divider and pin mux
    always_comb begin
        next_r = r;
        next_r.mode = oms_mode_e'(osc_select_bits);
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;
        case (r.mode)
            LOW_POWER_CRYSTAL_MODE, CRYSTAL_RESONATOR_MODE, HIGH_SPEED_CRYSTAL_MODE: begin
                next_r.src = SRC_RESONATOR;
                next_r.gpio_en = 2'h0;
            end
            EXT_RC_CLKOUT_MODE: begin
                next_r.src = SRC_EXT_RC;
                next_r.gpio_en = 2'h0;
            end
            EXT_RC_IO_MODE: begin
                next_r.src = SRC_EXT_RC;
                next_r.gpio_en = 2'h1;
            end
            INTERNAL_OSC_CLKOUT_MODE: begin
                next_r.src = SRC_INTERNAL;
                next_r.gpio_en = 2'h2;
            end
            INTERNAL_OSC_IO_MODE: begin
                next_r.src = SRC_INTERNAL;
                next_r.gpio_en = 2'h3;
            end
            EXTERNAL_CLOCK_IO_MODE: begin
                next_r.src = SRC_EXT_CLOCK;
                next_r.gpio_en = 2'h1;
            end
            default: begin
                next_r.src = SRC_RESONATOR;
                next_r.gpio_en = 2'h0;
            end
        endcase
        // start-up wait after reset and after sleep exit; skipped for external clock
        case (r.state)
            ST_START: begin
                next_r.clk_run = 1'b0;
                if (r.src == SRC_EXT_CLOCK || r.cnt == start_last) begin
                    next_r.state = ST_RUN;
                    next_r.clk_run = 1'b1;
                    next_r.cnt = '0;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    next_r.state = ST_SLEEP;
                    next_r.clk_run = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    next_r.cnt = '0;
                    if (r.src == SRC_EXT_CLOCK) begin
                        next_r.state = ST_RUN;
                        next_r.clk_run = 1'b1;
                    end else begin
                        next_r.state = ST_START;
                    end
                end
            end
            default: begin
                next_r.state = ST_START;
                next_r.clk_run = 1'b0;
            end
        endcase
        // quarter-rate divider, running only while clocked
        next_r.div = r.clk_run ? r.div + 1'b1 : 2'h0;
        // pin drive: clock out on bit 6 where asked, else gpio
        next_r.pins.out = port_wr_data & r.gpio_en;
        next_r.pins.oe = port_dir_out & r.gpio_en;
        if (r.mode == EXT_RC_CLKOUT_MODE || r.mode == INTERNAL_OSC_CLKOUT_MODE) begin
            next_r.pins.out[0] = r.clk_run && (r.div > OMS_DIV_HALF);
            next_r.pins.oe[0] = 1'b1;
        end
        // port reads: dedicated oscillator pins read zero
        next_r.port_rd = r.sync2 & r.gpio_en;
        // amplifier enable is registered so the output never glitches on a state change
        next_r.osc_drive = (next_r.src == SRC_RESONATOR) && (next_r.state != ST_SLEEP);
    end

    // state register, clean reset values
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mode = r.mode;
    assign clk_src = r.src;
    assign osc_drive_en = r.osc_drive;
    assign clk_run = r.clk_run;
    assign gpio_en = r.gpio_en;
    assign port_rd = r.port_rd;
    assign pin_out = r.pins.out;
    assign pin_oe = r.pins.oe;

    // mode groups for the checks below
    logic xtal_sel;
    logic clkout_sel;
    assign xtal_sel = r.mode == LOW_POWER_CRYSTAL_MODE || r.mode == CRYSTAL_RESONATOR_MODE
        || r.mode == HIGH_SPEED_CRYSTAL_MODE;
    assign clkout_sel = r.mode == EXT_RC_CLKOUT_MODE || r.mode == INTERNAL_OSC_CLKOUT_MODE;

    // checks: source and port bits trail the mode by one edge, so most look one edge on; the dedicated-pin check waits for a settled source
    a_crystal_pins_dedicated: assert property (@(posedge mclk) disable iff (!rst_n)
        xtal_sel && r.src == SRC_RESONATOR && $stable(r.src)
        |-> gpio_en == 2'h0 && port_rd == 2'h0 ##1 pin_oe == 2'h0)
        else $error("oscillator pins not dedicated");
    a_xtal_source: assert property (@(posedge mclk) disable iff (!rst_n)
        xtal_sel |=> clk_src == SRC_RESONATOR && gpio_en == 2'h0)
        else $error("crystal mode source wrong");
    // the wait counts from reset, so a source that settles late gets less than the full wait
    a_crystal_startup: assert property (@(posedge mclk) disable iff (!rst_n)
        r.state == ST_START && r.src == SRC_RESONATOR && r.cnt != start_last |=> !clk_run)
        else $error("crystal start-up skipped");
    a_sleep_halts: assert property (@(posedge mclk) disable iff (!rst_n)
        r.state == ST_RUN && sleep_req |=> !clk_run && !osc_drive_en)
        else $error("sleep left the clock running");
    a_ext_clock_fast: assert property (@(posedge mclk) disable iff (!rst_n)
        r.state == ST_START && r.src == SRC_EXT_CLOCK |=> clk_run)
        else $error("external clock waited for start-up");
    a_ext_wake_fast: assert property (@(posedge mclk) disable iff (!rst_n)
        r.state == ST_SLEEP && wake && r.src == SRC_EXT_CLOCK |=> clk_run)
        else $error("external clock waited after sleep");
    a_ext_clock_pin6: assert property (@(posedge mclk) disable iff (!rst_n)
        r.mode == EXTERNAL_CLOCK_IO_MODE |=> gpio_en == 2'h1)
        else $error("output pin not freed");
    a_rc_clkout_pins: assert property (@(posedge mclk) disable iff (!rst_n)
        r.mode == EXT_RC_CLKOUT_MODE |=> gpio_en == 2'h0 && clk_src == SRC_EXT_RC)
        else $error("rc clock-out mode wrong");
    a_rc_io_pin6: assert property (@(posedge mclk) disable iff (!rst_n)
        r.mode == EXT_RC_IO_MODE |=> gpio_en == 2'h1 && clk_src == SRC_EXT_RC)
        else $error("rc io mode wrong");
    a_int_clkout_pins: assert property (@(posedge mclk) disable iff (!rst_n)
        r.mode == INTERNAL_OSC_CLKOUT_MODE |=> gpio_en == 2'h2 && clk_src == SRC_INTERNAL)
        else $error("internal clock-out mode wrong");
    a_int_io_both: assert property (@(posedge mclk) disable iff (!rst_n)
        r.mode == INTERNAL_OSC_IO_MODE |=> gpio_en == 2'h3 && clk_src == SRC_INTERNAL)
        else $error("internal io mode wrong");
    a_clkout_drive_en: assert property (@(posedge mclk) disable iff (!rst_n)
        clkout_sel |=> pin_oe[0])
        else $error("clock out pin not driven");
    // a rising clock-out edge while the mode is settled starts a period
    sequence s_clkout_rise;
        clkout_sel && $stable(r.mode) && $rose(pin_out[0]);
    endsequence
    // the clock must stay released for the period to be judged; sleep cuts it short
    sequence s_run_two;
        (clk_run && clkout_sel)[*2];
    endsequence
    sequence s_run_four;
        (clk_run && clkout_sel)[*4];
    endsequence
    // second high cycle, then the first low one
    sequence s_high_half;
        pin_out[0] ##1 !pin_out[0];
    endsequence
    // second low cycle, then the next rise
    sequence s_low_half;
        !pin_out[0] ##1 pin_out[0];
    endsequence
    a_clkout_quarter: assert property (@(posedge mclk) disable iff (!rst_n)
        s_clkout_rise ##0 s_run_four |-> s_low_half)
        else $error("clock out not a quarter rate");
    a_clkout_period: assert property (@(posedge mclk) disable iff (!rst_n)
        s_clkout_rise ##0 s_run_two |-> s_high_half)
        else $error("clock out period wrong");
    a_mode_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        1'h1 |=> mode == $past(osc_select_bits))
        else $error("mode does not follow select bits");
endmodule
`default_nettype wire

// [oms_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
// far side of the two oscillator pins: a clock source or a plain pin load
module oms_far_side (
    // control
    input wire logic mclk,
    input wire logic ext_clk_on,
    input wire logic [1:0] load_lvl,
    // pins (bit 0 = port bit 6, bit 1 = port bit 7)
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    output logic [1:0] pin_lvl
);
    logic osc = 1'b0;
    // the clock stands still unless the external clock mode wants it
    always @(posedge mclk) osc <= ext_clk_on ? ~osc : 1'b0;
    // whoever drives a wire sets it, the load otherwise
    assign pin_lvl[0] = pin_oe[0] ? pin_out[0] : load_lvl[0];
    assign pin_lvl[1] = ext_clk_on ? osc : (pin_oe[1] ? pin_out[1] : load_lvl[1]);
endmodule
`default_nettype wire

// [test_oscillator_mode_select.sv]
`timescale 1ns/1ps
`default_nettype none
module test_oscillator_mode_select;
    import oms_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] sel = 3'h0;
    logic sleep_req = 1'b0;
    logic wake = 1'b0;
    logic [1:0] wr = 2'h0;
    logic [1:0] dir = 2'h0;
    logic [1:0] load = 2'h3;
    logic [2:0] mode;
    logic [1:0] clk_src, gpio_en, port_rd, pin_out, pin_oe, lvl;
    logic osc_drive_en, clk_run;
    int error_cnt = 0;
    int compares = 0;
    logic [1:0] g, s, c;
    logic [7:0] sq;
    logic sq_ok;
    // 25 MHz system clock
    always #20 mclk = ~mclk;
    // small start-up count keeps the run short
    oms_select #(.STARTUP_CYC(4)) uut (.mclk(mclk), .rst_n(rst_n), .osc_select_bits(sel),
        .sleep_req(sleep_req), .wake(wake), .port_wr_data(wr), .port_dir_out(dir),
        .pin_in(lvl), .mode(mode), .clk_src(clk_src), .osc_drive_en(osc_drive_en),
        .clk_run(clk_run), .gpio_en(gpio_en), .port_rd(port_rd), .pin_out(pin_out),
        .pin_oe(pin_oe));
    oms_far_side far (.mclk(mclk), .ext_clk_on(sel == 3'h3), .load_lvl(load),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(lvl));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // sample just after the edges have landed
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one pass per mode; the select is nonvolatile so each pass starts from reset
    initial begin
        for (int m = 0; m < 8; m++) begin
            g = (m == 3 || m == 6) ? 2'h1 : (m == 4) ? 2'h3 : (m == 5) ? 2'h2 : 2'h0;
            s = (m < 3) ? 2'h0 : (m == 3) ? 2'h3 : (m < 6) ? 2'h2 : 2'h1;
            c = (m == 5 || m == 7) ? 2'h1 : 2'h0;
            @(posedge mclk);
            rst_n <= 1'b0;
            sel <= m[2:0];
            dir <= 2'h0;
            wr <= 2'h0;
            tick(2);
            @(posedge mclk);
            rst_n <= 1'b1;
            // mode lands one edge after release, source and port bits one edge later
            tick(3);
            chk(8'(mode), 8'(m));
            chk(8'(clk_run), 8'(m == 3));
            chk(8'(clk_src), 8'(s));
            chk(8'(gpio_en), 8'(g));
            chk(8'(osc_drive_en), 8'(m < 3));
            // the four-cycle start-up ends on the next edge in every mode but external clock, which already runs
            tick(1);
            chk(8'(clk_run), 8'h01);
            for (int i = 0; i < 20 && clk_run !== 1'b1; i++) tick(1);
            if (clk_run !== 1'b1) begin
                error_cnt++;
                finish_test();
            end
            chk(8'(port_rd), 8'(g));
            // drive high on every port bit: only free bits may take it
            @(posedge mclk);
            dir <= 2'h3;
            wr <= 2'h3;
            tick(3);
            chk(8'(pin_oe), 8'(g | c));
            chk(8'(pin_out & g), 8'(g));
            chk(8'(pin_out & ~(g | c)), 8'h00);
            // quarter-rate output: two high, two low
            for (int i = 0; i < 8; i++) begin
                sq[i] = pin_out[0];
                tick(1);
            end
            sq_ok = (sq[7:4] == sq[3:0]) && ($countones(sq) == 4) && (sq[0] != sq[2]);
            if (c[0]) chk(8'(sq_ok), 8'h01);
            // sleep then wake: only the external clock comes back at once
            @(posedge mclk);
            sleep_req <= 1'b1;
            @(posedge mclk);
            sleep_req <= 1'b0;
            tick(2);
            chk(8'(clk_run), 8'h00);
            chk(8'(osc_drive_en), 8'h00);
            @(posedge mclk);
            wake <= 1'b1;
            @(posedge mclk);
            wake <= 1'b0;
            tick(2);
            chk(8'(clk_run), 8'(m == 3));
            // the oscillator modes wait the full start-up again after sleep
            tick(2);
            chk(8'(clk_run), 8'h01);
            chk(8'(osc_drive_en), 8'(m < 3));
            $display("mode %0d test done, mismatches %0d", m, error_cnt);
        end
        finish_test();
    end
endmodule
`default_nettype wire
